// [core/pin_function_select.sv]
// pin function multiplexing for port A bits 4..6 and port B bit 1
// assumes peripherals and config registers share mclk; pins are raw pads
//
// Overview of operation
// R1 - port A bit4 analog input four
// R2 - port A bit4 packet trace frame output
// R3 - port A bit4 cpu trace bit two
// R4 - port A bit5 analog input five
// R5 - port A bit5 packet trace data output
// R6 - boot strap sampled on the fifth clock edge after reset release
// R7 - port A bit5 cpu trace bit three
// R8 - port A bit6 timer one channel three
// R9 - timer one channel three input fixed
// R10 - port B bit1 spi data out
// R11 - port B bit1 twi open-drain data
// R12 - port B bit1 uart transmit
// R13 - timer two channel one on bit1
// R14 - irq c and d from any pin
// R15 - unselected pins act as gpio
`timescale 1ns/10ps
module pin_function_select
   import pin_select_pkg::*;
(
   input wire logic mclk, // 20 MHz system clock
   input wire logic rst_b, // async reset, active low
   input wire logic clkEn, // freezes all state when low
   input wire logic [15:0] portAHighConfig, // port A high config word
   input wire logic [15:0] portBLowConfig, // port B low config word
   input wire logic [3:0] timerOneOutputEnables, // timer 1 cc enables
   input wire logic [3:0] timerTwoOutputEnables, // timer 2 cc enables
   input wire logic [7:0] timerTwoRemapOption, // timer 2 remap bits
   input wire serial_mode_t serial1ModeSelect, // serial 1 mode
   input wire logic serial1SpiMaster, // spi config: 1 master
   input wire trace_ctl_t traceCtl, // cpu and packet trace controls
   input wire logic [3:0] gpioOut, // gpio data: b1,a6,a5,a4
   input wire logic packetTraceFrame, // packet trace frame source
   input wire logic packetTraceData, // packet trace data source
   input wire logic cpuTraceBit2, // cpu trace bit 2 source
   input wire logic cpuTraceBit3, // cpu trace bit 3 source
   input wire logic timerOneChanThreeOut, // timer 1 ch3 compare out
   input wire logic timerTwoChanOneOut, // timer 2 ch1 compare out
   input wire logic serial1SpiSlaveOut, // spi slave data out
   input wire logic serial1SpiMasterOut, // spi master data out
   input wire logic serial1TwiDataOut, // twi data, low pulls
   input wire logic serial1UartTx, // uart transmit data
   input wire logic [PIN_COUNT-1:0] allPinsIn, // all digital pin levels
   input wire logic [PIN_SEL_W-1:0] extIrqCPinSelect, // irq c pin
   input wire logic [PIN_SEL_W-1:0] extIrqDPinSelect, // irq d pin
   input wire logic [3:0] padIn, // raw pads: b1,a6,a5,a4
   output logic [3:0] padOut, // pad output level
   output logic [3:0] padOe, // pad output enable, high drives
   output logic [3:0] padAnalog, // analog switch closed
   output logic [3:0] gpioIn, // synchronised gpio input
   output logic analogInputFour, // analog path four enabled
   output logic analogInputFive, // analog path five enabled
   output logic timerOneChanThreeIn, // timer 1 ch3 capture input
   output logic serial1TwiDataIn, // twi data sampled from pin
   output logic externalInterruptC, // routed irq c level
   output logic externalInterruptD, // routed irq d level
   output logic factoryInfoMonitor // boot into factory monitor
);
   // ****************************************************
   // input synchronisers
   // ****************************************************
   logic [3:0] padSync;
   logic [3:0] pinCfg [4];
   logic [3:0] altValid;
   logic [3:0] altData;
   pad_t pads [4];

   generate
      for (genvar i = 0; i < 4; i++)
      begin : g_pin
         in_sync3 u_sync
         (
            .mclk(mclk),
            .rst_b(rst_b),
            .clkEn(clkEn),
            .din(padIn[i]),
            .resetVal(1'b1),
            .dout(padSync[i])
         );
         pad_cell_logic u_pad
         (
            .cfg(pinCfg[i]),
            .altValid(altValid[i]),
            .altData(altData[i]),
            .gpioOut(gpioOut[i]),
            .padIn(padSync[i]),
            .pad(pads[i])
         );
         assign padOut[i] = pads[i].drive; // R15
         assign padOe[i] = pads[i].driveEn; // R15
         assign padAnalog[i] = pads[i].analog;
         assign gpioIn[i] = pads[i].toCore; // R15
      end
   endgenerate

   // ****************************************************
   // field extraction
   // ****************************************************
   assign pinCfg[0] = portAHighConfig[A4_FIELD_LSB +: FIELD_W];
   assign pinCfg[1] = portAHighConfig[A5_FIELD_LSB +: FIELD_W];
   assign pinCfg[2] = portAHighConfig[A6_FIELD_LSB +: FIELD_W];
   assign pinCfg[3] = portBLowConfig[B1_FIELD_LSB +: FIELD_W];

   assign analogInputFour = pads[0].analog; // R1
   assign analogInputFive = pads[1].analog; // R4

   // ****************************************************
   // alternate source selection
   // ****************************************************
   logic cpuTraceOn;
   logic packetOn;
   logic timerTwoOwnsB1;
   logic serialOwnsB1;

   always_comb
   begin
      cpuTraceOn = traceCtl.traceEnabled & traceCtl.fourWire;
      // packet trace needs the cpu trace interface switched off
      packetOn = ~traceCtl.traceEnabled & traceCtl.packetTraceEn;
      timerTwoOwnsB1 = timerTwoRemapOption[REMAP_BIT]
         & timerTwoOutputEnables[TIM_CH1_BIT];
      serialOwnsB1 = ~timerTwoOwnsB1;

      altValid = 4'h0;
      altData = 4'h0;
      if (cpuTraceOn)
      begin
         altValid[0] = 1'b1; // R3
         altData[0] = cpuTraceBit2; // R3
         altValid[1] = 1'b1; // R7
         altData[1] = cpuTraceBit3; // R7
      end
      else if (packetOn)
      begin
         altValid[0] = 1'b1; // R2
         altData[0] = packetTraceFrame; // R2
         altValid[1] = 1'b1; // R5
         altData[1] = packetTraceData; // R5
      end
      if (timerOneOutputEnables[TIM_CH3_BIT])
      begin
         altValid[2] = 1'b1; // R8
         altData[2] = timerOneChanThreeOut; // R8
      end
      if (timerTwoOwnsB1)
      begin
         altValid[3] = 1'b1; // R13
         altData[3] = timerTwoChanOneOut; // R13
      end
      else if (serialOwnsB1)
      begin
         unique case (serial1ModeSelect)
            SER_SPI:
            begin
               altValid[3] = 1'b1; // R10
               altData[3] = serial1SpiMaster ? serial1SpiMasterOut
                  : serial1SpiSlaveOut; // R10
            end
            SER_TWI:
            begin
               altValid[3] = 1'b1; // R11
               altData[3] = serial1TwiDataOut; // R11
            end
            SER_UART:
            begin
               altValid[3] = 1'b1; // R12
               altData[3] = serial1UartTx; // R12
            end
            SER_OFF:
            begin
               altValid[3] = 1'b0;
            end
         endcase
      end
   end

   // capture path is hard wired to this pin, no remap
   assign timerOneChanThreeIn = padSync[2]; // R9
   assign serial1TwiDataIn = padSync[3];

   // ****************************************************
   // external interrupt routing
   // ****************************************************
   logic [PIN_COUNT-1:0] allSync;
   logic external_interrupt_c_r;
   logic external_interrupt_c_nxt;
   logic external_interrupt_d_r;
   logic external_interrupt_d_nxt;

   generate
      for (genvar j = 0; j < PIN_COUNT; j++)
      begin : g_irq
         in_sync3 u_isync
         (
            .mclk(mclk),
            .rst_b(rst_b),
            .clkEn(clkEn),
            .din(allPinsIn[j]),
            .resetVal(1'b1),
            .dout(allSync[j])
         );
      end
   endgenerate

   always_comb
   begin
      external_interrupt_c_nxt = external_interrupt_c_r;
      external_interrupt_d_nxt = external_interrupt_d_r;
      if (clkEn)
      begin
         // out of range selects read as idle low
         external_interrupt_c_nxt = (32'(extIrqCPinSelect) < PIN_COUNT)
            ? allSync[extIrqCPinSelect] : 1'b0; // R14
         external_interrupt_d_nxt = (32'(extIrqDPinSelect) < PIN_COUNT)
            ? allSync[extIrqDPinSelect] : 1'b0; // R14
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         external_interrupt_c_r <= 1'b0;
         external_interrupt_d_r <= 1'b0;
      end
      else
      begin
         external_interrupt_c_r <= external_interrupt_c_nxt;
         external_interrupt_d_r <= external_interrupt_d_nxt;
      end
   end

   assign externalInterruptC = external_interrupt_c_r;
   assign externalInterruptD = external_interrupt_d_r;

   // ****************************************************
   // boot strap capture
   // ****************************************************
   // strap is low-active; the filter shows its reset level for a few
   // edges after release, so the pad is read only once it has come through
   localparam logic [2:0] STRAP_LOOK = 3'(SYNC_STAGES + 1);
   logic [2:0] strapWait_r;
   logic [2:0] strapWait_nxt;
   logic monitor_r;
   logic monitor_nxt;

   always_comb
   begin
      strapWait_nxt = strapWait_r;
      monitor_nxt = monitor_r;
      if (clkEn && strapWait_r <= STRAP_LOOK)
      begin
         strapWait_nxt = strapWait_r + 3'h1; // R6
         if (strapWait_r == STRAP_LOOK)
            monitor_nxt = ~padSync[1]; // R6
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         strapWait_r <= 3'h0;
         monitor_r <= 1'b0;
      end
      else
      begin
         strapWait_r <= strapWait_nxt;
         monitor_r <= monitor_nxt;
      end
   end

   assign factoryInfoMonitor = monitor_r;
endmodule

// [shared/pin_select_pkg.sv]
// pin function select package: config field codes, modes, pin groups
// assumes a single 20 MHz clock domain and no register bus
package pin_select_pkg;
   // ****************************************************
   // configuration field layout
   // ****************************************************
   localparam int A4_FIELD_LSB = 0;
   localparam int A5_FIELD_LSB = 4;
   localparam int A6_FIELD_LSB = 8;
   localparam int B1_FIELD_LSB = 4;
   localparam int FIELD_W = 4;
   localparam int REMAP_BIT = 4;
   localparam int TIM_CH1_BIT = 0;
   localparam int TIM_CH3_BIT = 2;
   localparam int PIN_COUNT = 24;
   localparam int PIN_SEL_W = 5;
   localparam int SYNC_STAGES = 3;

   // pin mode codes inside each four-bit field
   localparam logic [3:0] CFG_ANALOG = 4'h0;
   localparam logic [3:0] CFG_OUT = 4'h1;
   localparam logic [3:0] CFG_OUT_OD = 4'h5;
   localparam logic [3:0] CFG_IN = 4'h4;
   localparam logic [3:0] CFG_IN_PULL = 4'h8;
   localparam logic [3:0] CFG_ALT_OUT = 4'h9;
   localparam logic [3:0] CFG_ALT_OD = 4'hD;
   localparam logic [3:0] CFG_RESET = 4'h4;

   // serial controller mode select codes
   typedef enum logic [1:0]
   {
      SER_OFF = 2'b00,
      SER_UART = 2'b01,
      SER_SPI = 2'b10,
      SER_TWI = 2'b11
   } serial_mode_t;

   // ****************************************************
   // carriers
   // ****************************************************
   typedef struct packed
   {
      logic toCore;
      logic drive;
      logic driveEn;
      logic analog;
   } pad_t;

   typedef struct packed
   {
      logic traceDisabledN;
      logic traceEnabled;
      logic fourWire;
      logic packetTraceEn;
   } trace_ctl_t;
endpackage

// [core/pad_cell_logic.sv]
// one pin's output selection: analog, alternate, open-drain or gpio
// assumes all selection inputs come from the same clock domain
`timescale 1ns/10ps
module pad_cell_logic
   import pin_select_pkg::*;
(
   input wire logic [3:0] cfg, // four-bit mode field
   input wire logic altValid, // some alternate source owns the pin
   input wire logic altData, // alternate source data
   input wire logic gpioOut, // general output data bit
   input wire logic padIn, // synchronised pad level
   output pad_t pad // combined pad controls
);
   always_comb
   begin
      pad.analog = (cfg == CFG_ANALOG);
      pad.toCore = pad.analog ? 1'b0 : padIn;
      pad.drive = 1'b0;
      pad.driveEn = 1'b0;
      unique case (cfg)
         CFG_OUT:
         begin
            pad.drive = gpioOut;
            pad.driveEn = 1'b1;
         end
         CFG_OUT_OD:
         begin
            pad.driveEn = ~gpioOut;
         end
         CFG_ALT_OUT:
         begin
            // no owner: fall back to gpio data so the pin is never floating
            pad.drive = altValid ? altData : gpioOut;
            pad.driveEn = 1'b1;
         end
         CFG_ALT_OD:
         begin
            pad.driveEn = altValid ? ~altData : ~gpioOut;
         end
         default:
         begin
            pad.driveEn = 1'b0;
         end
      endcase
   end
endmodule

// [core/in_sync3.sv]
// three-flop synchroniser with agreement filter on stages two and three
// assumes one clock, async active-low reset, clock enable
`timescale 1ns/10ps
module in_sync3
   import pin_select_pkg::*;
(
   input wire logic mclk, // system clock
   input wire logic rst_b, // async reset, active low
   input wire logic clkEn, // freezes state when low
   input wire logic din, // raw pad level
   input wire logic resetVal, // unused, reset always loads high
   output logic dout // filtered level
);
   logic [SYNC_STAGES-1:0] stage_r;
   logic [SYNC_STAGES-1:0] stage_nxt;
   logic dout_r;
   logic dout_nxt;

   always_comb
   begin
      stage_nxt = stage_r;
      dout_nxt = dout_r;
      if (clkEn)
      begin
         stage_nxt = {stage_r[SYNC_STAGES-2:0], din};
         // first stage is never looked at directly
         if (stage_r[1] == stage_r[2])
            dout_nxt = stage_r[2];
      end
   end

   always_ff @(posedge mclk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         stage_r <= '1;
         dout_r <= 1'b1;
      end
      else
      begin
         stage_r <= stage_nxt;
         dout_r <= dout_nxt;
      end
   end

   assign dout = resetVal ? dout_r : dout_r;
endmodule

// [verif/pad_world.sv]
// partner: board side of the four pads, drivers and floating nets
// assumes padOe high means the core drives the pad
`timescale 1ns/10ps
module pad_world
(
   input wire logic mclk, // system clock
   input wire logic [3:0] padOut, // core pad level
   input wire logic [3:0] padOe, // core drives the pad
   input wire logic [3:0] ext, // board driver level
   input wire logic [3:0] extEn, // board driver on
   output logic [3:0] padIn // level on the wire
);
   logic [3:0] float_r;
   // an undriven net toggles so a stale level never passes for a value
   initial
      float_r = 4'h5;
   always @(posedge mclk)
      float_r <= ~float_r;
   always_comb
      for (int i = 0; i < 4; i++)
         padIn[i] = padOe[i] ? padOut[i] : (extEn[i] ? ext[i] : float_r[i]);
endmodule

// [verif/pin_function_select_chk.sv]
// checker: pin selection relations seen at the top ports
// assumes one clock mclk and async active-low rst_b
`timescale 1ns/10ps
module pin_function_select_chk
   import pin_select_pkg::*;
(
   input wire logic mclk, // clock
   input wire logic rst_b, // reset, active low
   input wire logic clkEn, // run enable
   input wire logic [15:0] portAHighConfig, // port A fields
   input wire logic [15:0] portBLowConfig, // port B fields
   input wire logic [3:0] timerOneOutputEnables, // timer 1 enables
   input wire logic [3:0] timerTwoOutputEnables, // timer 2 enables
   input wire logic [7:0] timerTwoRemapOption, // timer 2 remap
   input wire serial_mode_t serial1ModeSelect, // serial mode
   input wire logic serial1SpiMaster, // spi master
   input wire trace_ctl_t traceCtl, // trace controls
   input wire logic [3:0] gpioOut, // gpio data
   input wire logic cpuTraceBit2, // trace source
   input wire logic packetTraceData, // packet source
   input wire logic timerOneChanThreeOut, // timer 1 source
   input wire logic timerTwoChanOneOut, // timer 2 source
   input wire logic serial1SpiSlaveOut, // spi slave source
   input wire logic serial1SpiMasterOut, // spi master source
   input wire logic serial1TwiDataOut, // twi source
   input wire logic serial1UartTx, // uart source
   input wire logic [3:0] padIn, // pad levels
   input wire logic [3:0] padOut, // pad drive
   input wire logic [3:0] padOe, // pad enable
   input wire logic [3:0] padAnalog, // analog switch
   input wire logic analogInputFour, // analog four
   input wire logic analogInputFive, // analog five
   input wire logic timerOneChanThreeIn // timer 1 capture in
);
   // ****************************************************
   // relations
   // ****************************************************
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_b);
   logic [3:0] fa4, fa5, fa6, fb1;
   logic t2Own, serAlt;
   assign fa4 = portAHighConfig[3:0];
   assign fa5 = portAHighConfig[7:4];
   assign fa6 = portAHighConfig[11:8];
   assign fb1 = portBLowConfig[7:4];
   assign t2Own = timerTwoRemapOption[4] && timerTwoOutputEnables[0];
   assign serAlt = fb1 == CFG_ALT_OUT && !t2Own;
   AST_A4_ANALOG: assert property (fa4 == CFG_ANALOG |->
      padAnalog[0] && analogInputFour) else $error("a4 analog off");
   AST_A5_ANALOG: assert property (fa5 == CFG_ANALOG |->
      padAnalog[1] && analogInputFive) else $error("a5 analog off");
   AST_A4_TRACE: assert property (fa4 == CFG_ALT_OUT && traceCtl.fourWire
      && traceCtl.traceEnabled |-> padOe[0] && padOut[0] == cpuTraceBit2)
      else $error("a4 trace bit wrong");
   AST_A5_PKT: assert property (fa5 == CFG_ALT_OUT
      && traceCtl.packetTraceEn && !traceCtl.traceEnabled
      |-> padOe[1] && padOut[1] == packetTraceData)
      else $error("a5 packet data wrong");
   AST_A6_TMR: assert property (fa6 == CFG_ALT_OUT
      && timerOneOutputEnables[2]
      |-> padOe[2] && padOut[2] == timerOneChanThreeOut)
      else $error("a6 timer out wrong");
   AST_T1_IN: assert property ((clkEn && $stable(padIn[2]))[*6] |->
      timerOneChanThreeIn == padIn[2]) else $error("timer 1 input stale");
   AST_B1_T2: assert property (fb1 == CFG_ALT_OUT && t2Own |->
      padOe[3] && padOut[3] == timerTwoChanOneOut) else $error("b1 timer2");
   AST_B1_UART: assert property (serAlt && serial1ModeSelect == SER_UART
      |-> padOe[3] && padOut[3] == serial1UartTx) else $error("b1 uart");
   AST_B1_SPI: assert property (serAlt && serial1ModeSelect == SER_SPI
      |-> padOe[3] && padOut[3] == (serial1SpiMaster ? serial1SpiMasterOut
      : serial1SpiSlaveOut)) else $error("b1 spi data wrong");
   AST_B1_TWI: assert property (fb1 == CFG_ALT_OD && !t2Own &&
      serial1ModeSelect == SER_TWI |-> padOe[3] == !serial1TwiDataOut
      && !(padOe[3] && padOut[3])) else $error("b1 twi not open drain");
   AST_GPIO_OUT: assert property (fa6 == CFG_OUT |->
      padOe[2] && padOut[2] == gpioOut[2]) else $error("a6 gpio out wrong");
endmodule

bind pin_function_select pin_function_select_chk chk (.*);

// [verif/pin_function_select_bench.sv]
// bench: drives pin selection inputs and judges pad and core sides
// assumes pad_world closes the pads and the checker is bound in
`timescale 1ns/10ps
module pin_function_select_bench
   import pin_select_pkg::*;
();
   logic mclk = 1'b0;
   logic rst_b, clkEn, serial1SpiMaster;
   logic packetTraceFrame, packetTraceData, cpuTraceBit2, cpuTraceBit3;
   logic timerOneChanThreeOut, timerTwoChanOneOut, serial1UartTx;
   logic serial1SpiSlaveOut, serial1SpiMasterOut, serial1TwiDataOut;
   logic [15:0] portAHighConfig, portBLowConfig;
   logic [7:0] timerTwoRemapOption;
   logic [3:0] timerOneOutputEnables, timerTwoOutputEnables, gpioOut;
   logic [3:0] padIn, padOut, padOe, padAnalog, gpioIn, ext, extEn;
   logic [23:0] allPinsIn;
   logic [4:0] extIrqCPinSelect, extIrqDPinSelect;
   logic analogInputFour, analogInputFive, timerOneChanThreeIn;
   logic serial1TwiDataIn, externalInterruptC, externalInterruptD;
   logic factoryInfoMonitor;
   serial_mode_t serial1ModeSelect;
   trace_ctl_t traceCtl;
   int mismatches = 0;
   int checks_done = 0;

   always #25 mclk = ~mclk;

   pin_function_select dut (.*);
   pad_world world (.mclk(mclk), .padOut(padOut), .padOe(padOe),
      .ext(ext), .extEn(extEn), .padIn(padIn));

   // ****************************************************
   // helpers
   // ****************************************************
   task automatic chk(string what, logic exp, logic got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("[ERR] %s expected %b seen %b", what, exp, got);
      end
   endtask

   task automatic settle(int n);
      repeat (n) @(posedge mclk);
      @(negedge mclk);
   endtask

   task automatic doReset();
      @(posedge mclk);
      rst_b <= 1'b0;
      repeat (3) @(posedge mclk);
      rst_b <= 1'b1;
   endtask

   // trace against packet, spi master against slave and timer 2 against uart carry opposite levels so a swapped mux shows
   task automatic setSrc(logic v);
      @(posedge mclk);
      {cpuTraceBit2, cpuTraceBit3, timerOneChanThreeOut, serial1UartTx,
         serial1SpiSlaveOut, serial1TwiDataOut} <= {6{v}};
      {packetTraceFrame, packetTraceData, timerTwoChanOneOut,
         serial1SpiMasterOut} <= {4{~v}};
   endtask

   // ****************************************************
   // scenarios
   // ****************************************************
   task automatic tStrap(logic low);
      @(posedge mclk);
      portAHighConfig <= 16'h0444;
      ext <= {2'b11, ~low, 1'b1};
      doReset();
      settle(6);
      chk("monitor", low, factoryInfoMonitor);
   endtask

   task automatic tPortA(logic v);
      @(posedge mclk);
      portAHighConfig <= 16'h0000;
      settle(1);
      chk("analog4", 1'b1, analogInputFour);
      chk("analog5", 1'b1, analogInputFive);
      @(posedge mclk);
      portAHighConfig <= 16'h0099;
      traceCtl <= '{1'b1, 1'b1, 1'b1, 1'b1};
      settle(1);
      chk("trace2", v, padOut[0]);
      chk("trace3", v, padOut[1]);
      @(posedge mclk);
      traceCtl <= '{1'b0, 1'b0, 1'b0, 1'b1};
      settle(1);
      chk("pktFrame", ~v, padOut[0]);
      chk("pktData", ~v, padOut[1]);
      chk("pktOe", 1'b1, padOe[1]);
   endtask

   task automatic tPortA6(logic v);
      @(posedge mclk);
      portAHighConfig <= 16'h0900;
      timerOneOutputEnables <= 4'h4;
      gpioOut <= {4{~v}};
      ext <= {4{v}};
      settle(1);
      chk("tim1Out", v, padOut[2]);
      @(posedge mclk);
      timerOneOutputEnables <= 4'h0;
      settle(1);
      chk("noOwner", ~v, padOut[2]);
      @(posedge mclk);
      portAHighConfig <= 16'h0100;
      settle(1);
      chk("gpioOe", 1'b1, padOe[2]);
      @(posedge mclk);
      portAHighConfig <= 16'h0400;
      settle(5);
      chk("tim1In", v, timerOneChanThreeIn);
      chk("gpioIn", v, gpioIn[2]);
   endtask

   task automatic tPortB(logic v);
      @(posedge mclk);
      portBLowConfig <= 16'h0090;
      serial1ModeSelect <= SER_UART;
      timerTwoOutputEnables <= 4'h1;
      timerTwoRemapOption <= 8'h00;
      settle(1);
      chk("uart", v, padOut[3]);
      @(posedge mclk);
      serial1ModeSelect <= SER_SPI;
      serial1SpiMaster <= 1'b1;
      settle(1);
      chk("spiMaster", ~v, padOut[3]);
      @(posedge mclk);
      serial1SpiMaster <= 1'b0;
      settle(1);
      chk("spiSlave", v, padOut[3]);
      @(posedge mclk);
      timerTwoRemapOption <= 8'h10;
      settle(1);
      chk("timer2", ~v, padOut[3]);
      @(posedge mclk);
      portBLowConfig <= 16'h00D0;
      serial1ModeSelect <= SER_TWI;
      timerTwoOutputEnables <= 4'h0;
      settle(5);
      chk("twiOe", ~v, padOe[3]);
      chk("twiLow", 1'b0, padOut[3] & padOe[3]);
      chk("twiIn", v, serial1TwiDataIn);
   endtask

   task automatic tIrq(logic v);
      @(posedge mclk);
      extIrqCPinSelect <= 5'h00;
      extIrqDPinSelect <= 5'h17;
      allPinsIn <= {v, {22{~v}}, ~v};
      settle(5);
      chk("external_interrupt_c", ~v, externalInterruptC);
      chk("external_interrupt_d", v, externalInterruptD);
      // with the enable low the routed level must not follow the pins
      @(posedge mclk);
      clkEn <= 1'b0;
      allPinsIn <= ~allPinsIn;
      settle(5);
      chk("irqHeld", ~v, externalInterruptC);
      @(posedge mclk);
      clkEn <= 1'b1;
      settle(5);
      chk("irqRun", v, externalInterruptC);
   endtask

   task automatic summarize();
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial
   begin
      {rst_b, serial1SpiMaster, packetTraceFrame, packetTraceData} = '0;
      {cpuTraceBit2, cpuTraceBit3, timerOneChanThreeOut} = '0;
      {timerTwoChanOneOut, serial1UartTx, serial1SpiSlaveOut} = '0;
      {serial1SpiMasterOut, serial1TwiDataOut, timerTwoRemapOption} = '0;
      {portAHighConfig, portBLowConfig, gpioOut, allPinsIn} = '0;
      {timerOneOutputEnables, timerTwoOutputEnables} = '0;
      {extIrqCPinSelect, extIrqDPinSelect} = '0;
      clkEn = 1'b1;
      ext = 4'hF;
      extEn = 4'hF;
      traceCtl = '0;
      serial1ModeSelect = SER_OFF;
      doReset();
      tStrap(1'b1);
      tStrap(1'b0);
      for (int i = 0; i < 2; i++)
      begin
         setSrc(i[0]);
         tPortA(i[0]);
         tPortA6(i[0]);
         tPortB(i[0]);
         tIrq(i[0]);
      end
      summarize();
   end
endmodule
